// *** acb_config.sv ***
// configuration registers and bank select of the bus gate array
`timescale 1ns/1ps
module acb_config (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [3:0] memory_jumper,
    input wire logic io_sel,
    input wire logic [11:0] io_off,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic io_rdata_oe,
    output logic zero_ws,
    input wire logic [19:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [19:0] vec_ptr,
    output logic buf_sel,
    output logic [15:0] buf_addr,
    input wire logic lan_irq_in,
    output logic lan_irq_out,
    input wire logic dma_active,
    input wire logic tc_pulse,
    input wire logic dma_irq_clr,
    output logic dma_irq,
    output logic test_rate_en
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0] cfg_r, cfg_nxt;
    logic [3:0] win_r, win_nxt;
    logic cap_done_r, cap_done_nxt;
    logic dma_irq_r, dma_irq_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic oe_r, oe_nxt;
    logic buf_sel_r, buf_sel_nxt;
    logic [15:0] buf_addr_r, buf_addr_nxt;
    logic hit_win, hit_cfg, vec_hit;

    acb_map_if m ();

    assign m.host_addr = mem_addr;
    assign m.window = win_r;
    assign m.map_en = cfg_r[acb_pkg::CFG_MAP_EN];
    assign m.bank = cfg_r[acb_pkg::CFG_BANK_HI:acb_pkg::CFG_BANK_LO];

    acb_window_dec acb_window_dec_i (
        .m(m.dec)
    );

    // ------------------------------------------------------------------
    // io decode and combinational outputs
    // ------------------------------------------------------------------
    assign hit_win = io_sel && io_off == acb_pkg::OFF_WINDOW_CFG;
    assign hit_cfg = io_sel && io_off == acb_pkg::OFF_ARRAY_CFG;
    assign vec_hit = mem_rd && mem_addr == vec_ptr;
    assign zero_ws = cfg_r[acb_pkg::CFG_ZERO_WS] && (io_rd || io_wr) &&
                     (hit_win || hit_cfg);
    assign lan_irq_out = lan_irq_in &&
                         !cfg_r[acb_pkg::CFG_LAN_MASK];
    assign test_rate_en = cfg_r[acb_pkg::CFG_TEST];
    assign io_rdata = rdata_r;
    assign io_rdata_oe = oe_r;
    assign dma_irq = dma_irq_r;
    assign buf_sel = buf_sel_r;
    assign buf_addr = buf_addr_r;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        cfg_nxt = cfg_r;
        win_nxt = win_r;
        cap_done_nxt = 1'b1;
        dma_irq_nxt = dma_irq_r;
        rdata_nxt = 8'h00;
        oe_nxt = io_rd && (hit_win || hit_cfg);
        if (!cap_done_r) begin
            win_nxt = memory_jumper;
        end
        if (io_wr && hit_cfg) begin
            cfg_nxt = io_wdata;
        end
        if (vec_hit) begin
            cfg_nxt[acb_pkg::CFG_MAP_EN] = 1'b0;
        end
        if (dma_irq_clr) begin
            dma_irq_nxt = 1'b0;
        end
        if (tc_pulse && dma_active && !cfg_r[acb_pkg::CFG_TC_MASK]) begin
            dma_irq_nxt = 1'b1;
        end
        if (io_rd && hit_win) begin
            rdata_nxt = {win_r, acb_pkg::WIN_LOW_ZERO};
        end else if (io_rd && hit_cfg) begin
            rdata_nxt = cfg_r;
        end
        buf_sel_nxt = m.hit && (mem_rd || mem_wr);
        buf_addr_nxt = m.local_addr;
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_r <= acb_pkg::ARRAY_CFG_RST;
            win_r <= acb_pkg::WINDOW_RST;
            cap_done_r <= 1'b0;
            dma_irq_r <= 1'b0;
            rdata_r <= 8'h00;
            oe_r <= 1'b0;
            buf_sel_r <= 1'b0;
            buf_addr_r <= 16'h0000;
        end else begin
            cfg_r <= cfg_nxt;
            win_r <= win_nxt;
            cap_done_r <= cap_done_nxt;
            dma_irq_r <= dma_irq_nxt;
            rdata_r <= rdata_nxt;
            oe_r <= oe_nxt;
            buf_sel_r <= buf_sel_nxt;
            buf_addr_r <= buf_addr_nxt;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    chk_window_frozen: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        cap_done_r |=> win_r == $past(win_r))
        else $error("window config changed after capture");

    chk_window_read: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        io_rd && hit_win |=> io_rdata_oe && io_rdata[3:0] == 4'h0 &&
            io_rdata[7:4] == $past(win_r))
        else $error("window config read wrong");

    chk_lan_gate: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        lan_irq_out == (lan_irq_in && !cfg_r[acb_pkg::CFG_LAN_MASK]))
        else $error("lan interrupt gating wrong");

    chk_tc_sets: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        tc_pulse && dma_active && !cfg_r[acb_pkg::CFG_TC_MASK]
            |=> dma_irq)
        else $error("terminal count lost");

    chk_tc_masked: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        !dma_irq && cfg_r[acb_pkg::CFG_TC_MASK] |=> !dma_irq)
        else $error("masked completion interrupt set");

    chk_zero_wait: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        zero_ws |-> cfg_r[acb_pkg::CFG_ZERO_WS] && io_sel)
        else $error("zero wait outside own io");

    chk_map_off: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        !cfg_r[acb_pkg::CFG_MAP_EN] |=> !buf_sel && buf_addr == 16'h0000)
        else $error("buffer mapped while mapping off");

    chk_bank_lines: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        buf_sel |-> buf_addr[15:13] == $past(cfg_r[2:0]) &&
            buf_addr[12:0] == $past(mem_addr[12:0]))
        else $error("bank lines wrong");

    chk_vec_clear: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        vec_hit |=> !cfg_r[acb_pkg::CFG_MAP_EN])
        else $error("vector match left mapping on");

    chk_cfg_readback: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        io_wr && hit_cfg && !vec_hit ##1 io_rd && hit_cfg && !io_wr
            |=> io_rdata == $past(io_wdata, 2))
        else $error("config readback wrong");

    chk_cfg_write: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        io_wr && hit_cfg && !vec_hit |=> cfg_r == $past(io_wdata))
        else $error("config write lost");

    chk_read_oe: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        !(io_rd && (hit_win || hit_cfg)) |=> !io_rdata_oe &&
            io_rdata == 8'h00)
        else $error("read data driven without register read");

    // decoder-independent view of one window
    chk_window_hit: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (mem_rd || mem_wr) && cfg_r[acb_pkg::CFG_MAP_EN] &&
            win_r[acb_pkg::WIN_DC] && mem_addr[19:13] == acb_pkg::BASE_DC
            |=> buf_sel)
        else $error("window cycle not mapped");

    chk_dma_clear: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        dma_irq_clr && !tc_pulse |=> !dma_irq)
        else $error("completion interrupt not cleared");
endmodule // acb_config

// *** acb_host_model.sv ***
// host side model: memory jumper, dma transfer and terminal count
`timescale 1ns/1ps
module acb_host_model #(
    parameter logic [3:0] JUMPER = 4'h8
) (
    input wire logic core_clk,
    input wire logic tc_req,
    output logic [3:0] memory_jumper,
    output logic dma_active,
    output logic tc_pulse
);
    // jumper held in one of the four window positions
    assign memory_jumper = JUMPER;
    // one terminal count pulse inside each requested transfer
    always @(posedge core_clk) begin
        dma_active <= tc_req;
        tc_pulse <= tc_req && dma_active;
    end
endmodule // acb_host_model

// *** acb_map_if.sv ***
// carrier between configuration core and window decoder
`timescale 1ns/1ps
interface acb_map_if;
    logic [19:0] host_addr;
    logic [3:0] window;
    logic map_en;
    logic [2:0] bank;
    logic hit;
    logic [15:0] local_addr;
    modport core (
        output host_addr,
        output window,
        output map_en,
        output bank,
        input hit,
        input local_addr
    );
    modport dec (
        input host_addr,
        input window,
        input map_en,
        input bank,
        output hit,
        output local_addr
    );
endinterface

// *** acb_pkg.sv ***
// constants for the adapter configuration and bank select block
package acb_pkg;
    // ------------------------------------------------------------------
    // register offsets within the gate array io space
    // ------------------------------------------------------------------
    localparam logic [11:0] OFF_WINDOW_CFG = 12'h404;
    localparam logic [11:0] OFF_ARRAY_CFG = 12'h405;
    // ------------------------------------------------------------------
    // array_configuration field positions and reset value
    // ------------------------------------------------------------------
    localparam int CFG_LAN_MASK = 7;
    localparam int CFG_TC_MASK = 6;
    localparam int CFG_ZERO_WS = 5;
    localparam int CFG_TEST = 4;
    localparam int CFG_MAP_EN = 3;
    localparam int CFG_BANK_HI = 2;
    localparam int CFG_BANK_LO = 0;
    localparam logic [7:0] ARRAY_CFG_RST = 8'h00;
    // ------------------------------------------------------------------
    // memory_window_config layout: one-hot window in bits 7 to 4
    // ------------------------------------------------------------------
    localparam int WIN_LSB = 4;
    localparam logic [3:0] WIN_LOW_ZERO = 4'h0;
    localparam logic [3:0] WINDOW_RST = 4'h0;
    // window index inside the one-hot field
    localparam int WIN_DC = 3;
    localparam int WIN_D8 = 2;
    localparam int WIN_CC = 1;
    localparam int WIN_C8 = 0;
    // host address bits 19 to 13 of each 8k window
    localparam logic [6:0] BASE_DC = 7'h6E;
    localparam logic [6:0] BASE_D8 = 7'h6C;
    localparam logic [6:0] BASE_CC = 7'h66;
    localparam logic [6:0] BASE_C8 = 7'h64;
endpackage

// *** acb_window_dec.sv ***
// host memory window decoder and bank address former
`timescale 1ns/1ps
module acb_window_dec (
    acb_map_if.dec m
);
    // ------------------------------------------------------------------
    // window match
    // ------------------------------------------------------------------
    function automatic logic win_match(input logic [3:0] win,
                                       input logic [6:0] a);
        win_match = (win[acb_pkg::WIN_DC] && a == acb_pkg::BASE_DC) ||
                    (win[acb_pkg::WIN_D8] && a == acb_pkg::BASE_D8) ||
                    (win[acb_pkg::WIN_CC] && a == acb_pkg::BASE_CC) ||
                    (win[acb_pkg::WIN_C8] && a == acb_pkg::BASE_C8);
    endfunction

    always_comb begin
        // bank lines are ignored while mapping is off
        m.hit = m.map_en && win_match(m.window, m.host_addr[19:13]);
        if (m.hit) begin
            m.local_addr = {m.bank, m.host_addr[12:0]};
        end else begin
            m.local_addr = 16'h0000;
        end
    end
endmodule // acb_window_dec

// *** adapter_config_and_bank_select_tb.sv ***
// testbench for configuration registers and bank select
`timescale 1ns/1ps
module adapter_config_and_bank_select_tb;
    logic core_clk = 1'b0, arst_n = 1'b0, io_sel = 1'b0, io_rd = 1'b0;
    logic io_wr = 1'b0, mem_rd = 1'b0, mem_wr = 1'b0, lan_irq_in = 1'b0;
    logic tc_req = 1'b0, dma_irq_clr = 1'b0, io_rdata_oe, zero_ws;
    logic [11:0] io_off = 12'h000;
    logic [7:0] io_wdata = 8'h00, io_rdata;
    logic [19:0] mem_addr = 20'h00000, vec_ptr = 20'hFFFF0;
    logic [3:0] memory_jumper;
    logic dma_active, tc_pulse, buf_sel, lan_irq_out, dma_irq, test_rate_en;
    logic [15:0] buf_addr;
    int n_fail = 0, n_tests = 0;
    always #25 core_clk = ~core_clk;
    acb_host_model acb_host_model_i (.core_clk(core_clk), .tc_req(tc_req),
        .memory_jumper(memory_jumper), .dma_active(dma_active),
        .tc_pulse(tc_pulse));
    acb_config acb_config_i (.core_clk(core_clk), .arst_n(arst_n),
        .memory_jumper(memory_jumper), .io_sel(io_sel), .io_off(io_off),
        .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .io_rdata_oe(io_rdata_oe), .zero_ws(zero_ws),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .vec_ptr(vec_ptr), .buf_sel(buf_sel), .buf_addr(buf_addr),
        .lan_irq_in(lan_irq_in), .lan_irq_out(lan_irq_out),
        .dma_active(dma_active), .tc_pulse(tc_pulse),
        .dma_irq_clr(dma_irq_clr), .dma_irq(dma_irq),
        .test_rate_en(test_rate_en));
    // ------------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // register and memory cycles
    // ------------------------------------------------------------------
    task automatic wr(input logic [11:0] off, input logic [7:0] d);
        @(posedge core_clk);
        io_sel <= 1'b1;
        io_off <= off;
        io_wr <= 1'b1;
        io_wdata <= d;
        @(posedge core_clk);
        io_sel <= 1'b0;
        io_wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] off, input logic [7:0] exp,
        input logic ws);
        @(posedge core_clk);
        io_sel <= 1'b1;
        io_off <= off;
        io_rd <= 1'b1;
        #1 check(16'(zero_ws), 16'(ws));
        @(posedge core_clk);
        io_sel <= 1'b0;
        io_rd <= 1'b0;
        #1 check(16'(io_rdata), 16'(exp));
        check(16'(io_rdata_oe), 16'(off[11:1] == 11'h202));
    endtask
    task automatic mrd(input logic [19:0] a, input logic [16:0] exp);
        @(posedge core_clk);
        mem_rd <= 1'b1;
        mem_addr <= a;
        @(posedge core_clk);
        mem_rd <= 1'b0;
        #1 check(16'(buf_sel), 16'(exp[16]));
        check(buf_addr, exp[15:0]);
    endtask
    task automatic mwr(input logic [19:0] a, input logic [16:0] exp);
        @(posedge core_clk);
        mem_wr <= 1'b1;
        mem_addr <= a;
        @(posedge core_clk);
        mem_wr <= 1'b0;
        #1 check(16'(buf_sel), 16'(exp[16]));
        check(buf_addr, exp[15:0]);
    endtask
    task automatic dma_done(input logic exp);
        @(posedge core_clk);
        tc_req <= 1'b1;
        repeat (2) @(posedge core_clk);
        tc_req <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1 check(16'(dma_irq), 16'(exp));
        @(posedge core_clk);
        dma_irq_clr <= 1'b1;
        @(posedge core_clk);
        dma_irq_clr <= 1'b0;
        #1 check(16'(dma_irq), 16'h0000);
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial begin
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        rd(12'h404, 8'h80, 1'b0);
        wr(12'h404, 8'h5A);
        rd(12'h404, 8'h80, 1'b0);
        rd(12'h405, 8'h00, 1'b0);
        wr(12'h405, 8'h21);
        rd(12'h405, 8'h21, 1'b1);
        rd(12'h406, 8'h00, 1'b0);
        mrd(20'hDC123, 17'h00000);
        for (int b = 0; b < 4; b++) begin
            wr(12'h405, 8'h08 | 8'(b));
            mrd(20'hDC123, {1'b1, 3'(b), 13'h0123});
        end
        @(posedge core_clk);
        io_sel <= 1'b1;
        io_off <= 12'h405;
        io_wr <= 1'b1;
        io_wdata <= 8'h0B;
        @(posedge core_clk);
        io_wr <= 1'b0;
        io_rd <= 1'b1;
        @(posedge core_clk);
        io_sel <= 1'b0;
        io_rd <= 1'b0;
        #1 check(16'(io_rdata), 16'h000B);
        mrd(20'hD8123, 17'h00000);
        wr(12'h405, 8'h09);
        vec_ptr <= 20'hC0010;
        mwr(20'hC0010, 17'h00000);
        mwr(20'hDC123, 17'h12123);
        mrd(20'hC0010, 17'h00000);
        mrd(20'hDC123, 17'h00000);
        rd(12'h405, 8'h01, 1'b0);
        @(posedge core_clk);
        lan_irq_in <= 1'b1;
        #1 check(16'(lan_irq_out), 16'h0001);
        wr(12'h405, 8'h80);
        #1 check(16'(lan_irq_out), 16'h0000);
        dma_done(1'b1);
        wr(12'h405, 8'h40);
        dma_done(1'b0);
        wr(12'h405, 8'h10);
        #1 check(16'(test_rate_en), 16'h0001);
        summarize();
    end
    initial begin
        #200000;
        n_fail++;
        summarize();
    end
endmodule // adapter_config_and_bank_select_tb
